// ---- inc/dspiv_pkg.sv ----
/*
 Constants, field positions and shared functions of the interrupt
 vectoring block. Assumes a 32-bit control word path and sixteen
 interrupt slots.
*/
package dspiv_pkg;
    // Slot numbering and table geometry
    localparam int DSPIV_NINT = 16;
    localparam int DSPIV_NMASK = 12;
    localparam int DSPIV_MASK_LO = 4;
    localparam logic [3:0] DSPIV_NMI_NUM = 4'h1;
    localparam int DSPIV_PKT_LSB = 5;
    localparam int DSPIV_BASE_LSB = 10;
    localparam int DSPIV_BASEW = 22;
    localparam logic [31:0] DSPIV_RESET_ADDR = 32'h0;
    localparam logic [21:0] DSPIV_BASE_RST = 22'h0;
    // Flag and enable layouts
    localparam logic [15:0] DSPIV_FLAG_MASK = 16'hfff2;
    localparam logic [15:0] DSPIV_IE_MASK = 16'hfff0;
    localparam int DSPIV_NONMASK_ENABLE_BIT = 1;
    localparam int DSPIV_GIE_BIT = 0;
    localparam int DSPIV_PRIOR_GLOBAL_ENABLE_BIT = 1;
    // Control register move selects
    localparam logic [2:0] DSPIV_SEL_CSR = 3'h0;
    localparam logic [2:0] DSPIV_SEL_IER = 3'h1;
    localparam logic [2:0] DSPIV_SEL_IFR = 3'h2;
    localparam logic [2:0] DSPIV_SEL_ICR = 3'h3;
    localparam logic [2:0] DSPIV_SEL_VECTOR_TABLE_POINTER = 3'h4;

    // Lowest set index from 1 upward, zero when none
    function automatic logic [4:0] dspivFirst(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h0;
        for (int i = 15; i >= 1; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // Packet address: base, slot number, 32-byte packet offset
    function automatic logic [31:0] dspivVecAddr(input logic [21:0] base, input logic [4:0] num);
        return {base, num, 5'h0};
    endfunction
endpackage

// ---- inc/dspiv_sel_if.sv ----
/*
 Carrier between the pending flag store and the priority selector.
 Assumes the owner drives enables, gie and blocked.
*/
`timescale 1ns/10ps
interface dspiv_sel_if;
    logic [15:0] flags;
    logic [15:0] enables;
    logic global_int_enable;
    logic blocked;
    logic [4:0] topNum;
    logic takeValid;
    logic [3:0] takeNum;
    modport pend (output flags, input takeValid, input takeNum);
    modport prio (input flags, input enables, input global_int_enable, input blocked,
                  output topNum, output takeValid, output takeNum);
endinterface

// ---- rtl/dspiv_pending.sv ----
/*
 Pending flag store: sets from input events and software, clears
 on software clear and on acceptance. Assumes single clock domain.
*/
`timescale 1ns/10ps
module dspiv_pending
    import dspiv_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Set and clear sources
    input wire logic [15:0] setEvt,
    input wire logic [15:0] swSet,
    input wire logic [15:0] swClr,
    // Selector side
    dspiv_sel_if.pend sel
);
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] takeMask;

    assign takeMask = sel.takeValid ? (16'h1 << sel.takeNum) : 16'h0;
    // Set wins over any clear in the same cycle
    assign flags_next = ((flags_reg & ~swClr & ~takeMask) | setEvt | swSet) & DSPIV_FLAG_MASK;

    always_ff @(posedge clock) begin
        if (srst) begin
            flags_reg <= 16'h0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign sel.flags = flags_reg;

    set_wins_a: assert property (@(posedge clock) disable iff (srst)
        (|(setEvt & DSPIV_FLAG_MASK)) |=> ((flags_reg & $past(setEvt) & DSPIV_FLAG_MASK)
            == ($past(setEvt) & DSPIV_FLAG_MASK)))
        else $error("event lost in pending flags");

    take_clear_a: assert property (@(posedge clock) disable iff (srst)
        sel.takeValid && !(setEvt[sel.takeNum] || swSet[sel.takeNum]) |=> !flags_reg[$past(sel.takeNum)])
        else $error("accepted flag not cleared");
endmodule

// ---- rtl/dspiv_priority.sv ----
/*
 Priority selection: highest priority pending enabled number for the table
 pointer, and the acceptance decision. Assumes registered inputs.
*/
`timescale 1ns/10ps
module dspiv_priority
    import dspiv_pkg::*;
(
    // Clock and reset, checks only
    input wire logic clock,
    input wire logic srst,
    // Selector side
    dspiv_sel_if.prio sel
);
    logic [4:0] firstFlag;
    logic nmiGo;
    logic maskGo;

    // Individual enables only, NMI gated by its own enable
    assign sel.topNum = dspivFirst(sel.flags & sel.enables & DSPIV_FLAG_MASK);
    assign firstFlag = dspivFirst(sel.flags & DSPIV_FLAG_MASK);
    assign nmiGo = sel.flags[DSPIV_NMI_NUM] & sel.enables[DSPIV_NONMASK_ENABLE_BIT];
    // Highest flag only, with global and nonmaskable enables
    assign maskGo = sel.global_int_enable & sel.enables[DSPIV_NONMASK_ENABLE_BIT] & (firstFlag >= 5'(DSPIV_MASK_LO))
                    & sel.enables[firstFlag[3:0]];
    assign sel.takeValid = !sel.blocked & (nmiGo | maskGo);
    assign sel.takeNum = firstFlag[3:0];

    nmi_gate_a: assert property (@(posedge clock) disable iff (srst)
        sel.takeValid && sel.takeNum == DSPIV_NMI_NUM |-> sel.enables[DSPIV_NONMASK_ENABLE_BIT])
        else $error("nonmaskable taken while disabled");

    mask_gate_a: assert property (@(posedge clock) disable iff (srst)
        sel.takeValid && sel.takeNum != DSPIV_NMI_NUM
        |-> sel.global_int_enable && sel.enables[DSPIV_NONMASK_ENABLE_BIT] && sel.enables[sel.takeNum])
        else $error("maskable taken while disabled");

    delay_hold_a: assert property (@(posedge clock) disable iff (srst)
        sel.blocked |-> !sel.takeValid)
        else $error("interrupt taken in delay slot");

    top_prio_a: assert property (@(posedge clock) disable iff (srst)
        sel.takeValid |-> ((sel.flags & DSPIV_FLAG_MASK & ((16'h1 << sel.takeNum) - 16'h1)) == 16'h0))
        else $error("lower priority taken first");

    hpe_zero_a: assert property (@(posedge clock) disable iff (srst)
        ((sel.flags & sel.enables & DSPIV_FLAG_MASK) == 16'h0) |-> sel.topNum == 5'h0)
        else $error("top pending number not zero");
endmodule

// ---- rtl/dspiv_vectoring.sv ----
/*
 Interrupt acceptance and vectoring of the CPU core: enables,
 pending flags, priority, acknowledge and packet fetch address.
 Assumes pins are asynchronous, pipeline strobes are on clock.
*/
`timescale 1ns/10ps
module dspiv_vectoring
    import dspiv_pkg::*;
#(
    parameter int NMASK = DSPIV_NMASK
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Interrupt pins
    input wire logic nmiPin,
    input wire logic [NMASK-1:0] maskPins,
    // Pipeline status
    input wire logic inDelaySlot,
    input wire logic intReturn,
    // Control register move
    input wire logic [2:0] ctrlSel,
    input wire logic ctrlWrite,
    input wire logic ctrlRead,
    input wire logic [31:0] ctrlWrData,
    output logic [31:0] ctrlRdData,
    output logic ctrlRdValid,
    // Program fetch
    output logic fetchStrobe,
    output logic [31:0] fetchAddr,
    // Acknowledge to external hardware
    output logic intAck,
    output logic [3:0] vectorNumber
);
    dspiv_sel_if selBus();

    logic [NMASK:0] sync1_reg;
    logic [NMASK:0] sync2_reg;
    logic [NMASK:0] prev_reg;
    logic [NMASK:0] rise;
    logic [15:0] setEvt;
    logic [15:0] swSet;
    logic [15:0] swClr;
    logic nonmask_enable_reg;
    logic gie_reg;
    logic prior_global_enable_reg;
    logic [15:0] ier_reg;
    logic [DSPIV_BASEW-1:0] tableBase_reg;
    logic rstDone_reg;
    logic fetchStrobe_reg;
    logic [31:0] fetchAddr_reg;
    logic intAck_reg;
    logic [3:0] vectorNum_reg;
    logic [31:0] rdData_reg;
    logic rdValid_reg;
    logic [31:0] rdData_next;
    logic wrCsr;
    logic wrIer;
    logic wrIstp;
    logic takeNmi;
    logic takeMask;

    // Pin synchronisers, nonmaskable in the top bit
    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= {nmiPin, maskPins};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Rising transitions mark occurrences
    assign rise = sync2_reg & ~prev_reg;
    assign setEvt = {rise[NMASK-1:0], 2'b00, rise[NMASK], 1'b0};

    // Control register move decode
    assign wrCsr = ctrlWrite && (ctrlSel == DSPIV_SEL_CSR);
    assign wrIer = ctrlWrite && (ctrlSel == DSPIV_SEL_IER);
    assign wrIstp = ctrlWrite && (ctrlSel == DSPIV_SEL_VECTOR_TABLE_POINTER);
    assign swSet = (ctrlWrite && ctrlSel == DSPIV_SEL_IFR) ? (ctrlWrData[15:0] & DSPIV_FLAG_MASK) : 16'h0;
    assign swClr = (ctrlWrite && ctrlSel == DSPIV_SEL_ICR) ? (ctrlWrData[15:0] & DSPIV_FLAG_MASK) : 16'h0;

    assign takeNmi = selBus.takeValid && (selBus.takeNum == DSPIV_NMI_NUM);
    assign takeMask = selBus.takeValid && (selBus.takeNum != DSPIV_NMI_NUM);

    // Selector inputs
    assign selBus.enables = {ier_reg[15:4], 2'b00, nonmask_enable_reg, 1'b1};
    assign selBus.global_int_enable = gie_reg;
    assign selBus.blocked = inDelaySlot | !rstDone_reg;

    dspiv_pending uPend (
        .clock(clock),
        .srst(srst),
        .setEvt(setEvt),
        .swSet(swSet),
        .swClr(swClr),
        .sel(selBus)
    );

    dspiv_priority uPrio (
        .clock(clock),
        .srst(srst),
        .sel(selBus)
    );

    // Nonmaskable enable: set by software, cleared by nonmaskable acceptance
    always_ff @(posedge clock) begin
        if (srst) begin
            nonmask_enable_reg <= 1'b0;
        end else if (takeNmi) begin
            nonmask_enable_reg <= 1'b0;
        end else if (wrIer && ctrlWrData[DSPIV_NONMASK_ENABLE_BIT]) begin
            nonmask_enable_reg <= 1'b1;
        end
    end

    // Individual maskable enables
    always_ff @(posedge clock) begin
        if (srst) begin
            ier_reg <= 16'h0;
        end else if (wrIer) begin
            ier_reg <= ctrlWrData[15:0] & DSPIV_IE_MASK;
        end
    end

    // Global enable and its saved copy
    always_ff @(posedge clock) begin
        if (srst) begin
            gie_reg <= 1'b0;
            prior_global_enable_reg <= 1'b0;
        end else if (takeMask) begin
            prior_global_enable_reg <= wrCsr ? ctrlWrData[DSPIV_GIE_BIT] : gie_reg;
            gie_reg <= 1'b0;
        end else if (wrCsr) begin
            gie_reg <= ctrlWrData[DSPIV_GIE_BIT];
            prior_global_enable_reg <= ctrlWrData[DSPIV_PRIOR_GLOBAL_ENABLE_BIT];
        end else if (intReturn) begin
            gie_reg <= prior_global_enable_reg;
        end
    end

    // Table base, the only writable pointer field
    always_ff @(posedge clock) begin
        if (srst) begin
            tableBase_reg <= DSPIV_BASE_RST;
        end else if (wrIstp) begin
            tableBase_reg <= ctrlWrData[31:DSPIV_BASE_LSB];
        end
    end

    // Reset packet fetch, then acceptance fetches
    always_ff @(posedge clock) begin
        if (srst) begin
            rstDone_reg <= 1'b0;
            fetchStrobe_reg <= 1'b0;
            fetchAddr_reg <= DSPIV_RESET_ADDR;
        end else if (!rstDone_reg) begin
            rstDone_reg <= 1'b1;
            fetchStrobe_reg <= 1'b1;
            fetchAddr_reg <= DSPIV_RESET_ADDR;
        end else if (selBus.takeValid) begin
            fetchStrobe_reg <= 1'b1;
            fetchAddr_reg <= dspivVecAddr(tableBase_reg, {1'b0, selBus.takeNum});
        end else begin
            fetchStrobe_reg <= 1'b0;
        end
    end

    // Acknowledge and interrupt number
    always_ff @(posedge clock) begin
        if (srst) begin
            intAck_reg <= 1'b0;
            vectorNum_reg <= 4'h0;
        end else begin
            intAck_reg <= selBus.takeValid;
            if (selBus.takeValid) begin
                vectorNum_reg <= selBus.takeNum;
            end
        end
    end

    // Read multiplexer
    always_comb begin
        case (ctrlSel)
            DSPIV_SEL_CSR: begin
                rdData_next = {30'h0, prior_global_enable_reg, gie_reg};
            end
            DSPIV_SEL_IER: begin
                rdData_next = {16'h0, selBus.enables};
            end
            DSPIV_SEL_IFR: begin
                rdData_next = {16'h0, selBus.flags};
            end
            DSPIV_SEL_VECTOR_TABLE_POINTER: begin
                rdData_next = dspivVecAddr(tableBase_reg, selBus.topNum);
            end
            default: begin
                rdData_next = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rdData_reg <= 32'h0;
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= ctrlRead;
            if (ctrlRead) begin
                rdData_reg <= rdData_next;
            end
        end
    end

    assign ctrlRdData = rdData_reg;
    assign ctrlRdValid = rdValid_reg;
    assign fetchStrobe = fetchStrobe_reg;
    assign fetchAddr = fetchAddr_reg;
    assign intAck = intAck_reg;
    assign vectorNumber = vectorNum_reg;

    nonmask_enable_reset_a: assert property (@(posedge clock) disable iff (srst)
        !rstDone_reg |-> !nonmask_enable_reg)
        else $error("nonmaskable enable set after reset");

    nonmask_enable_clear_a: assert property (@(posedge clock) disable iff (srst)
        takeNmi |=> !nonmask_enable_reg ##1 (nonmask_enable_reg == $past(wrIer && ctrlWrData[DSPIV_NONMASK_ENABLE_BIT])))
        else $error("nonmaskable enable not cleared");

    nonmask_enable_sticky_a: assert property (@(posedge clock) disable iff (srst)
        nonmask_enable_reg && !takeNmi |=> nonmask_enable_reg)
        else $error("software cleared nonmaskable enable");

    gie_save_a: assert property (@(posedge clock) disable iff (srst)
        takeMask && !wrCsr |=> !gie_reg && (prior_global_enable_reg == $past(gie_reg)))
        else $error("global enable not saved");

    ack_num_a: assert property (@(posedge clock) disable iff (srst)
        selBus.takeValid |=> intAck && vectorNumber == $past(selBus.takeNum) && fetchStrobe
            && fetchAddr == dspivVecAddr($past(tableBase_reg), {1'b0, $past(selBus.takeNum)}))
        else $error("acknowledge or vector wrong");

    rst_fetch_a: assert property (@(posedge clock) disable iff (srst)
        !rstDone_reg |=> fetchStrobe && fetchAddr == DSPIV_RESET_ADDR && !intAck)
        else $error("reset packet not fetched from zero");

    vector_table_pointer_read_a: assert property (@(posedge clock) disable iff (srst)
        ctrlRead && ctrlSel == DSPIV_SEL_VECTOR_TABLE_POINTER |=> ctrlRdValid && ctrlRdData[4:0] == 5'h0
            && ctrlRdData[9:5] == $past(selBus.topNum))
        else $error("pointer low fields wrong");

    base_write_a: assert property (@(posedge clock) disable iff (srst)
        wrIstp |=> tableBase_reg == $past(ctrlWrData[31:DSPIV_BASE_LSB]) ##1 ($stable(tableBase_reg) || $past(wrIstp)))
        else $error("table base not written");
endmodule

// ---- bench/dspiv_src_model.sv ----
/*
 Far-side model of the interrupt sources: each fire bit raises its
 request pin for four clock cycles, then lets it fall low again.
 Assumes fire is driven on the same clock; pins are low from time zero.
*/
`timescale 1ns/10ps
module dspiv_src_model (
    // Clock
    input wire logic clock,
    // Request triggers, bit 12 nonmaskable, bits 11:0 maskable
    input wire logic [12:0] fire,
    // Request pins
    output logic nmiPin,
    output logic [11:0] maskPins
);
    logic [2:0] holdCnt [13] = '{default: 3'h0};
    logic [12:0] pinLevel;

    // Pulse long enough to pass the two-stage synchroniser
    always @(posedge clock) begin
        for (int i = 0; i < 13; i++) begin
            if (fire[i]) begin
                holdCnt[i] <= 3'h4;
            end else if (holdCnt[i] != 3'h0) begin
                holdCnt[i] <= holdCnt[i] - 3'h1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 13; i++) begin
            pinLevel[i] = (holdCnt[i] != 3'h0);
        end
    end

    assign nmiPin = pinLevel[12];
    assign maskPins = pinLevel[11:0];
endmodule

// ---- bench/tb_top.sv ----
/*
 Self-checking bench of the vectoring block: control moves, pin
 requests, delay slots and fetch addresses. Assumes the source model
 and the package are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
    import dspiv_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [12:0] fire = 13'h0;
    logic nmiPin;
    logic [11:0] maskPins;
    logic inDelaySlot = 1'b0;
    logic intReturn = 1'b0;
    logic [2:0] ctrlSel = 3'h0;
    logic ctrlWrite = 1'b0;
    logic ctrlRead = 1'b0;
    logic [31:0] ctrlWrData = 32'h0;
    logic [31:0] ctrlRdData;
    logic ctrlRdValid;
    logic fetchStrobe;
    logic [31:0] fetchAddr;
    logic intAck;
    logic [3:0] vectorNumber;
    int failCount = 0;
    int nTests = 0;

    always #50 clock = ~clock;

    dspiv_src_model i_src (.clock(clock), .fire(fire), .nmiPin(nmiPin), .maskPins(maskPins));

    dspiv_vectoring #(.NMASK(12)) i_dut (
        .clock(clock), .srst(srst), .nmiPin(nmiPin), .maskPins(maskPins),
        .inDelaySlot(inDelaySlot), .intReturn(intReturn), .ctrlSel(ctrlSel),
        .ctrlWrite(ctrlWrite), .ctrlRead(ctrlRead), .ctrlWrData(ctrlWrData),
        .ctrlRdData(ctrlRdData), .ctrlRdValid(ctrlRdValid), .fetchStrobe(fetchStrobe),
        .fetchAddr(fetchAddr), .intAck(intAck), .vectorNumber(vectorNumber)
    );

    task automatic wrap_up();
        if (failCount == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [31:0] data);
        @(posedge clock);
        ctrlSel <= sel;
        ctrlWrData <= data;
        ctrlWrite <= 1'b1;
        @(posedge clock);
        ctrlWrite <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] sel, input logic [31:0] exp);
        @(posedge clock);
        ctrlSel <= sel;
        ctrlRead <= 1'b1;
        @(posedge clock);
        ctrlRead <= 1'b0;
        #1;
        chk({31'h0, ctrlRdValid}, 32'h1);
        chk(ctrlRdData, exp);
    endtask

    task automatic pulse(input logic [12:0] m);
        @(posedge clock);
        fire <= m;
        @(posedge clock);
        fire <= 13'h0;
    endtask

    // Acknowledge must stay low for n cycles
    task automatic no_ack(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1;
            chk({31'h0, intAck}, 32'h0);
        end
    endtask

    // Bounded wait for a take, then its number and packet address
    task automatic wait_ack(input logic [3:0] vec, input logic [31:0] addr);
        bit got;
        got = 0;
        for (int i = 0; i < 12 && !got; i++) begin
            @(posedge clock);
            #1;
            got = (intAck === 1'b1);
        end
        if (!got) begin
            failCount++;
            wrap_up();
        end else begin
            chk({31'h0, fetchStrobe}, 32'h1);
            chk({28'h0, vectorNumber}, {28'h0, vec});
            chk(fetchAddr, addr);
        end
    endtask

    task automatic s_reset();
        @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        #1;
        chk({31'h0, fetchStrobe}, 32'h1);
        chk(fetchAddr, DSPIV_RESET_ADDR);
        chk({31'h0, intAck}, 32'h0);
        rd(DSPIV_SEL_IER, 32'h1);
        rd(DSPIV_SEL_VECTOR_TABLE_POINTER, 32'h0);
    endtask

    task automatic s_pointer();
        wr(DSPIV_SEL_VECTOR_TABLE_POINTER, 32'hffffffff);
        rd(DSPIV_SEL_VECTOR_TABLE_POINTER, 32'hfffffc00);
        rd(3'h5, 32'h0);
        wr(DSPIV_SEL_VECTOR_TABLE_POINTER, 32'h00000800);
        rd(DSPIV_SEL_VECTOR_TABLE_POINTER, 32'h00000800);
    endtask

    task automatic s_nmi();
        pulse(13'h1000);
        no_ack(8);
        rd(DSPIV_SEL_IFR, 32'h2);
        wr(DSPIV_SEL_IER, 32'h2);
        wait_ack(DSPIV_NMI_NUM, 32'h820);
        rd(DSPIV_SEL_IER, 32'h1);
        wr(DSPIV_SEL_IER, 32'h2);
        wr(DSPIV_SEL_IER, 32'h0);
        rd(DSPIV_SEL_IER, 32'h3);
    endtask

    task automatic s_mask();
        wr(DSPIV_SEL_IER, 32'h282);
        pulse(13'h0120);
        no_ack(8);
        rd(DSPIV_SEL_VECTOR_TABLE_POINTER, 32'h920);
        rd(DSPIV_SEL_IFR, 32'h1200);
        wr(DSPIV_SEL_CSR, 32'h1);
        wait_ack(4'h9, 32'h920);
        rd(DSPIV_SEL_CSR, 32'h2);
        wr(DSPIV_SEL_ICR, 32'h1000);
        rd(DSPIV_SEL_IFR, 32'h0);
    endtask

    task automatic s_slot();
        @(posedge clock);
        inDelaySlot <= 1'b1;
        intReturn <= 1'b1;
        @(posedge clock);
        intReturn <= 1'b0;
        rd(DSPIV_SEL_CSR, 32'h3);
        pulse(13'h1008);
        no_ack(8);
        rd(DSPIV_SEL_VECTOR_TABLE_POINTER, 32'h820);
        @(posedge clock);
        inDelaySlot <= 1'b0;
        wait_ack(DSPIV_NMI_NUM, 32'h820);
        no_ack(6);
        wr(DSPIV_SEL_IER, 32'h282);
        wait_ack(4'h7, 32'h8e0);
        rd(DSPIV_SEL_CSR, 32'h2);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        s_reset();
        s_pointer();
        s_nmi();
        s_mask();
        s_slot();
        wrap_up();
    end
endmodule
